// ==== hw/pst_map.svh ====
`ifndef PST_MAP_SVH
`define PST_MAP_SVH
`define PST_OFF_PCL      8'h00
`define PST_OFF_TBLP     8'h04
`define PST_OFF_TBHP     8'h08
`define PST_OFF_TBHI     8'h0C
`define PST_OFF_STAT     8'h10
`define PST_OFF_CMD      8'h14
`define PST_OFF_DLOW     8'h18
`define PST_RESET_VEC    11'h000
`define PST_LAST_PAGE    3'h7
`define PST_CMD_STEP     3'h1
`define PST_CMD_SKIP     3'h2
`define PST_CMD_JMP      3'h3
`define PST_CMD_CALL     3'h4
`define PST_CMD_RET      3'h5
`define PST_CMD_TBRD     3'h6
`define PST_CMD_TBRDL    3'h7
`endif

// ==== hw/pst_pkg.sv ====
package pst_pkg;
	typedef enum logic [1:0] {PST_IDLE, PST_DUMMY, PST_TABLE} pst_state_t;
endpackage

// ==== hw/pst_sequencer.sv ====
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
`include "pst_map.svh"
// How it works
// [RULE1] Program counter advances by one per executed instruction unless flow is redirected.
// [RULE2] Only the low eight counter bits are a software register.
// [RULE3] Jump, call, interrupt entry and reset load a target into the counter.
// [RULE4] A met skip discards the prefetched instruction and runs a dummy cycle.
// [RULE5] Counter is eleven bits: three high bits and eight low bits.
// [RULE6] Writing the low counter register jumps within the current 256-word page.
// [RULE7] Writing the low counter register inserts one dummy cycle.
// [RULE8] Return stack holds counter values only; stack and pointer are hidden from software.
// [RULE9] Call or interrupt acknowledge pushes the counter; either return pops it.
// [RULE10] After reset the stack pointer shows the empty top position.
// [RULE11] With the stack full an interrupt is held pending until a return frees a level.
// [RULE12] A call with the stack full proceeds and loses the oldest entry.
// [RULE13] Arithmetic results go to their register and update status flags; this module has no ALU and no flags.
// [RULE14] Program memory is 2K words of 16 bits, fetched by the counter.
// [RULE15] Execution starts at address zero after reset.
// [RULE16] Full-range table address takes high pointer bits 10..8 and low pointer bits 7..0.
// [RULE17] Last-page table address forces bits 10..8 high, low pointer gives 7..0.
// [RULE18] Table read puts low byte to the data register, high byte to the table-high register.
// [RULE19] Table-high register is read only; only table reads update it.
// [RULE20] Every table read takes two instruction cycles.
// [RULE21] Branches and calls take two instruction cycles.
// [RULE22] Stack depth is a parameter; full is derived from the level pointer.
module pst_sequencer #(
	parameter int DEPTH = 8,
	parameter int AW    = 11
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	input  wire logic          wb_we_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	output logic               wb_ack_o,
	input  wire logic [2:0]    op_i,
	input  wire logic          op_valid_i,
	input  wire logic [AW-1:0] target_i,
	input  wire logic          irq_req_i,
	output logic               irq_ack_o,
	output logic [AW-1:0]      fetch_addr_o,
	input  wire logic [15:0]   mem_data_i,
	output logic               busy_o,
	output logic [7:0]         table_low_o,
	output logic               table_low_valid_o
);

	localparam int SPW = $clog2(DEPTH + 1);

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [AW-1:0]        pc;
	logic [AW-1:0]        stack [DEPTH];
	logic [SPW-1:0]       level;
	logic [7:0]           tblp;
	logic [7:0]           tbhp;
	logic [7:0]           tbhi;
	logic [7:0]           tlow;
	logic [AW-1:0]        taddr;
	logic                 ack;
	logic                 tlv;
	logic                 irq_pend;
	pst_pkg::pst_state_t  state;

	////////////////////////////////////////////////////////////////////////////////
	// Decoding
	function automatic logic is_op(input logic [2:0] op, input logic [2:0] code);
		is_op = (op == code);
	endfunction

	wire         pcl_hold   = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i == `PST_OFF_PCL) &
	                          (state != pst_pkg::PST_IDLE);
	wire         acc        = wb_cyc_i & wb_stb_i & ~ack & ~pcl_hold;
	wire         wr         = acc & wb_we_i & wb_sel_i[0];
	// A low counter write while busy waits for idle, so its own dummy cycle is never swallowed
	wire         wr_pcl     = wr & (wb_adr_i == `PST_OFF_PCL) & (state == pst_pkg::PST_IDLE); // see [RULE7]
	wire         wr_tblp    = wr & (wb_adr_i == `PST_OFF_TBLP);
	wire         wr_tbhp    = wr & (wb_adr_i == `PST_OFF_TBHP);
	wire         idle       = (state == pst_pkg::PST_IDLE);
	wire         go         = op_valid_i & idle & ~wr_pcl;
	wire         full       = (level == SPW'(DEPTH));   // see [RULE22]
	wire         empty      = (level == '0);
	wire         do_step    = go & is_op(op_i, `PST_CMD_STEP);
	wire         do_skip    = go & is_op(op_i, `PST_CMD_SKIP);
	wire         do_jmp     = go & is_op(op_i, `PST_CMD_JMP);
	wire         do_call    = go & is_op(op_i, `PST_CMD_CALL);
	wire         do_ret     = go & is_op(op_i, `PST_CMD_RET);
	wire         do_tbrd    = go & is_op(op_i, `PST_CMD_TBRD);
	wire         do_tbrdl   = go & is_op(op_i, `PST_CMD_TBRDL);
	// Interrupt only taken while idle with no other command and a free level
	wire         take_irq   = (irq_req_i | irq_pend) & idle & ~op_valid_i & ~wr_pcl & ~full; // see [RULE11]
	wire         push       = do_call | take_irq;                  // see [RULE9]
	wire [AW-1:0] pc_inc    = pc + AW'(1);
	wire [AW-1:0] top       = stack[0];
	wire [AW-1:0] tab_full  = {tbhp[2:0], tblp};                   // see [RULE16]
	wire [AW-1:0] tab_last  = {`PST_LAST_PAGE, tblp};              // see [RULE17]
	wire [AW-1:0] pcl_tgt   = {pc[AW-1:8], wb_dat_i[7:0]};         // see [RULE6]

	logic [AW-1:0] next_pc;
	always_comb begin
		next_pc = pc;
		if (wr_pcl)
			next_pc = pcl_tgt;                                     // see [RULE6]
		else if (take_irq)
			next_pc = target_i;                                    // see [RULE3]
		else if (do_jmp | do_call)
			next_pc = target_i;                                    // see [RULE3]
		else if (do_ret)
			next_pc = top;                                         // see [RULE9]
		else if (do_step | do_skip | do_tbrd | do_tbrdl)
			next_pc = pc_inc;                                      // see [RULE1]
	end

	logic [31:0] rd;
	always_comb begin
		case (wb_adr_i)
			`PST_OFF_PCL:  rd = {24'h000000, pc[7:0]};             // see [RULE2]
			`PST_OFF_TBLP: rd = {24'h000000, tblp};
			`PST_OFF_TBHP: rd = {24'h000000, tbhp};
			`PST_OFF_TBHI: rd = {24'h000000, tbhi};
			`PST_OFF_STAT: rd = {30'h00000000, irq_pend, ~idle};
			`PST_OFF_DLOW: rd = {24'h000000, tlow};
			default:       rd = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Program counter and control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc       <= `PST_RESET_VEC;                            // see [RULE15]
			state    <= pst_pkg::PST_IDLE;
			irq_pend <= 1'b0;
		end else begin
			pc <= next_pc;                                         // see [RULE5]
			if (take_irq)
				irq_pend <= 1'b0;
			else if (irq_req_i)
				irq_pend <= 1'b1;                                  // see [RULE11]
			case (state)
				pst_pkg::PST_IDLE: begin
					if (wr_pcl | do_skip | do_jmp | do_call | do_ret | take_irq)
						state <= pst_pkg::PST_DUMMY;               // see [RULE4] [RULE7] [RULE21]
					else if (do_tbrd | do_tbrdl)
						state <= pst_pkg::PST_TABLE;               // see [RULE20]
				end
				pst_pkg::PST_DUMMY: state <= pst_pkg::PST_IDLE;
				pst_pkg::PST_TABLE: state <= pst_pkg::PST_IDLE;
				default:            state <= pst_pkg::PST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Return stack, entry 0 is the newest; a push when full drops the oldest
	always_ff @(posedge clk_i) begin
		if (rst_i)
			level <= '0;                                           // see [RULE10]
		else if (push & ~full)
			level <= level + SPW'(1);
		else if (do_ret & ~empty)
			level <= level - SPW'(1);                              // see [RULE9]
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_stk
			always_ff @(posedge clk_i) begin
				if (push)
					stack[g] <= (g == 0) ? (take_irq ? pc : pc_inc) : stack[(g == 0) ? 0 : g-1]; // see [RULE8] [RULE12]
				else if (do_ret)
					stack[g] <= (g == DEPTH-1) ? stack[g] : stack[(g == DEPTH-1) ? g : g+1];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Table pointers and table read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tblp  <= 8'h00;
			tbhp  <= 8'h00;
			tbhi  <= 8'h00;
			tlow  <= 8'h00;
			taddr <= `PST_RESET_VEC;
			tlv   <= 1'b0;
		end else begin
			tlv <= 1'b0;
			if (wr_tblp)
				tblp <= wb_dat_i[7:0];
			if (wr_tbhp)
				tbhp <= wb_dat_i[7:0];
			if (do_tbrd)
				taddr <= tab_full;
			else if (do_tbrdl)
				taddr <= tab_last;
			if (state == pst_pkg::PST_TABLE) begin
				tlow <= mem_data_i[7:0];                           // see [RULE18]
				tbhi <= mem_data_i[15:8];                          // see [RULE19]
				tlv  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus answer, one cycle after the request; a low counter write while busy is answered one cycle after idle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack      <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			ack      <= acc;
			wb_dat_o <= rd;
		end
	end

	// Program memory itself is outside; fetch uses the table address during the second cycle
	assign fetch_addr_o      = (state == pst_pkg::PST_TABLE) ? taddr : pc; // see [RULE14]
	assign wb_ack_o          = ack;
	assign irq_ack_o         = take_irq;
	assign busy_o            = ~idle;
	assign table_low_o       = tlow;
	assign table_low_valid_o = tlv;
	// ALU result and flag writes live in the execute unit, not here (RULE13 stays outside)

endmodule // pst_sequencer

// ==== verification/pst_prog_mem.sv ====
`timescale 1ns/10ps
module pst_prog_mem (
	input  wire logic [10:0] addr_i,
	output logic      [15:0] data_o
);
	// Low byte is address bits 7..0, high byte is 5'h0A above bits 10..8, so a fetch from the wrong page shows in the high byte
	assign data_o = {5'h0A, addr_i};
endmodule // pst_prog_mem

// ==== verification/pst_sequencer_chk.sv ====
`timescale 1ns/10ps
module pst_sequencer_chk #(
	parameter int AW = 11
) (
	input wire logic          clk_i,
	input wire logic          rst_i,
	input wire logic [7:0]    wb_adr_i,
	input wire logic [31:0]   wb_dat_i,
	input wire logic          wb_we_i,
	input wire logic [3:0]    wb_sel_i,
	input wire logic          wb_cyc_i,
	input wire logic          wb_stb_i,
	input wire logic          wb_ack_o,
	input wire logic [2:0]    op_i,
	input wire logic          op_valid_i,
	input wire logic [AW-1:0] target_i,
	input wire logic          irq_ack_o,
	input wire logic [AW-1:0] fetch_addr_o,
	input wire logic          busy_o,
	input wire logic          table_low_valid_o
);
	// A counter write wins over a command in the same cycle
	wire pclw = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & !wb_ack_o & (wb_adr_i == 8'h00);
	wire tk = op_valid_i & !busy_o & !pclw;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_redir; busy_o ##1 !busy_o; endsequence
	sequence s_tbl; busy_o ##1 table_low_valid_o; endsequence
	////////////////////////////////////////
	property p_step; tk && op_i == 3'h1 |=> fetch_addr_o == $past(fetch_addr_o) + 1'b1; endproperty
	a_step: assert property (p_step) else $error("counter did not advance");
	property p_jmp; tk && (op_i == 3'h3 || op_i == 3'h4) |=> (fetch_addr_o == $past(target_i)) ##0 s_redir; endproperty
	a_jmp: assert property (p_jmp) else $error("jump target or extra cycle wrong");
	property p_skip; tk && op_i == 3'h2 |=> s_redir; endproperty
	a_skip: assert property (p_skip) else $error("skip without dummy cycle");
	property p_tbl; tk && op_i[2:1] == 2'b11 |=> s_tbl; endproperty
	a_tbl: assert property (p_tbl) else $error("table read not two cycles");
	property p_last; tk && op_i == 3'h7 |=> fetch_addr_o[AW-1 -: 3] == 3'h7; endproperty
	a_last: assert property (p_last) else $error("last page bits not forced");
	property p_irq; irq_ack_o |-> !op_valid_i ##1 fetch_addr_o == $past(target_i); endproperty
	a_irq: assert property (p_irq) else $error("interrupt entry wrong");
	property p_pcl; pclw && !busy_o |=> busy_o && fetch_addr_o == {$past(fetch_addr_o[AW-1:8]), $past(wb_dat_i[7:0])};
	endproperty
	a_pcl: assert property (p_pcl) else $error("low counter write wrong");
	property p_rst; $fell(rst_i) |-> fetch_addr_o == '0 && !busy_o; endproperty
	a_rst: assert property (p_rst) else $error("not at reset vector");
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bus answer wrong");
endmodule // pst_sequencer_chk
bind pst_sequencer pst_sequencer_chk #(.AW(AW)) u_pst_sequencer_chk (.*);

// ==== verification/pst_sequencer_tb.sv ====
`timescale 1ns/10ps
module pst_sequencer_tb;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_we_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        op_valid_i = 1'b0;
	logic        irq_req_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [2:0]  op_i = 3'h0;
	logic [10:0] target_i = 11'h000;
	logic [31:0] rd;
	wire [31:0]  wb_dat_o;
	wire         wb_ack_o, irq_ack_o, busy_o, table_low_valid_o;
	wire [10:0]  fetch_addr_o;
	wire [15:0]  mem_data_i;
	wire [7:0]   table_low_o;
	int          mismatches = 0, checked = 0, acks = 0;
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (irq_ack_o === 1'b1) acks <= acks + 1;
	// Depth of two keeps the full-stack cases short
	pst_sequencer #(.DEPTH(2)) u_pst_sequencer (.*);
	pst_prog_mem u_pst_prog_mem (.addr_i(fetch_addr_o), .data_o(mem_data_i));
	////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		n = 0;
		// Ack is looked at mid-cycle, so the rising edge after it is the one that samples it high
		do begin @(negedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin mismatches++; end_of_test; end
		rd = wb_dat_o;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
	endtask
	task op(input logic [2:0] c, input logic [10:0] t);
		@(posedge clk_i);
		{op_valid_i, op_i, target_i} <= {1'b1, c, t};
		@(posedge clk_i);
		op_valid_i <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	////////////////////////////////////////
	task s_reset;
		chk(fetch_addr_o, 11'h000);
		wb(1'b0, 8'h00, 32'h0); chk(rd, 32'h0);
	endtask
	task s_flow;
		op(3'h1, 11'h0); op(3'h1, 11'h0); chk(fetch_addr_o, 11'h002);
		op(3'h2, 11'h0); chk(fetch_addr_o, 11'h003);
		op(3'h3, 11'h3F0); chk(fetch_addr_o, 11'h3F0);
		wb(1'b1, 8'h00, 32'h55); chk(fetch_addr_o, 11'h355);
		wb(1'b0, 8'h00, 32'h0); chk(rd, 32'h55);
	endtask
	task s_stack;
		op(3'h4, 11'h200); op(3'h5, 11'h0); chk(fetch_addr_o, 11'h356);
		op(3'h4, 11'h100); op(3'h4, 11'h180);
		@(posedge clk_i); irq_req_i <= 1'b1;
		@(posedge clk_i); irq_req_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(acks, 0);
		op(3'h5, 11'h7C0); repeat (3) @(posedge clk_i); #1;
		chk(acks, 1);
		chk(fetch_addr_o, 11'h7C0);
		op(3'h4, 11'h050); op(3'h5, 11'h0); chk(fetch_addr_o, 11'h7C1);
		op(3'h5, 11'h0); chk(fetch_addr_o, 11'h101);
	endtask
	task s_table;
		wb(1'b1, 8'h04, 32'h06); wb(1'b1, 8'h08, 32'h02); op(3'h6, 11'h0);
		chk(table_low_valid_o, 1'b1);
		chk(table_low_o, 8'h06);
		wb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h52);
		wb(1'b1, 8'h0C, 32'hFF); wb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h52);
		op(3'h7, 11'h0); wb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h57);
		wb(1'b0, 8'h20, 32'h0); chk(rd, 32'h0);
	endtask
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i); #1;
		s_reset; s_flow; s_stack; s_table;
		end_of_test;
	end
endmodule // pst_sequencer_tb
